// ### logic/watchdog_unit.sv
// Operation
// - Watchdog mode only when mode select and count enable are both one
// - Watchdog overflow drives the overflow output low for 128 cycles
// - With reset enable, overflow starts internal chip reset with the overflow output
// - Reset kind select picks power-on or manual internal reset
// - Internal chip reset lasts 512 cycles
// - External reset pin wins over overflow reset and clears the overflow flag
// - Watchdog reset leaves port, pin function and I/O registers untouched
// - Interval mode raises an interrupt on every counter overflow
// - Interval overflow flag sets in the same cycle as the interrupt
// - Standby refused while count enable is one
// - NMI in standby restarts counting at the pre-standby divider rate
// - Counter wrap during standby recovery releases clocks and ends standby
// - Watchdog overflow flag sets together with the overflow output
// - Counter write beats a coinciding increment
// - Without reset enable, overflow clears counter and timer control only
// - 16-bit keyed writes load the lower byte into counter or control
// - Counter held at zero while count enable is zero, except during standby wake-up
// - Divider select chooses one of eight rates from /2 to /8192
// - Key A5 with zero clears the overflow flag; key 5A loads reset fields
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module watchdog_unit
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Chip-level pins and events
  input  wire logic        i_external_reset_pin_n,
  input  wire logic        i_nmi,
  // Outputs to chip
  output logic             o_overflow_out_n,
  output logic             o_chip_reset,
  output logic             o_chip_reset_manual,
  output logic             o_interval_irq,
  output logic             o_clock_release,
  output logic             o_in_standby
);

  logic [7:0]   tick_counter_q;
  logic         ovf_flag_q;
  logic         mode_select_bit_q;
  logic         count_enable_bit_q;
  logic [2:0]   clock_divider_select_q;
  logic         wd_overflow_flag_q;
  logic         chip_reset_enable_q;
  logic         reset_kind_select_q;
  logic         standby_refused_q;
  pwr_state_e   pwr_q;
  logic [1:0]   pin_sync_q;
  logic [1:0]   nmi_sync_q;
  logic         pin_rst;
  logic         nmi_s;
  logic         tick;
  logic         run;
  logic         wrap;
  logic         wd_ovf;
  logic         it_ovf;
  logic         wake_done;
  logic         wr_en;
  logic         key_wr;
  logic         ovf_active;
  logic         rst_active;
  logic         rst_start;

  // Pins pass two flops before use
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_sync_q <= 2'h3;
      nmi_sync_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], i_external_reset_pin_n};
      nmi_sync_q <= {nmi_sync_q[0], i_nmi};
    end
  end
  assign pin_rst = !pin_sync_q[1];
  assign nmi_s   = nmi_sync_q[1];

  // APB: zero wait states; keyed writes need both low byte lanes
  assign wr_en  = i_psel && i_penable && i_pwrite;
  assign key_wr = wr_en && (i_pstrb[1:0] == 2'h3);

  // Counter runs in normal operation or during standby wake-up
  assign run  = (pwr_q == ST_WAKE) || (count_enable_bit_q && (pwr_q == ST_RUN));
  assign wrap = tick && (tick_counter_q == 8'hFF);
  assign wd_ovf    = wrap && (pwr_q == ST_RUN) && mode_select_bit_q;
  assign it_ovf    = wrap && (pwr_q == ST_RUN) && !mode_select_bit_q;
  assign wake_done = wrap && (pwr_q == ST_WAKE);
  assign rst_start = wd_ovf && chip_reset_enable_q && !pin_rst;

  wdt_prescaler u_presc (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (run),
    .i_sel      (clock_divider_select_q),
    .o_tick     (tick)
  );

  wdt_pulse u_ovf_pulse (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_start    (wd_ovf),
    .i_last     (OVF_PULSE_LAST),
    .o_active   (ovf_active)
  );

  wdt_pulse u_rst_pulse (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_start    (rst_start),
    .i_last     (RST_PULSE_LAST),
    .o_active   (rst_active)
  );

  // Tick counter
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_counter_q <= COUNTER_RESET;
    end else if (pin_rst) begin
      tick_counter_q <= COUNTER_RESET;
    end else if (wd_ovf && !chip_reset_enable_q) begin
      tick_counter_q <= COUNTER_RESET;
    end else if (key_wr && i_paddr == ADDR_CTRL_STATUS && i_pwdata[15:8] == KEY_COUNTER) begin
      tick_counter_q <= i_pwdata[7:0];
    end else if (!run) begin
      tick_counter_q <= COUNTER_RESET;
    end else if (tick) begin
      tick_counter_q <= tick_counter_q + 8'h01;
    end
  end

  // Timer control/status; overflow flag set wins over a clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovf_flag_q             <= CTRL_RESET[CTRL_OVF_BIT];
      mode_select_bit_q      <= CTRL_RESET[CTRL_MODE_BIT];
      count_enable_bit_q     <= CTRL_RESET[CTRL_EN_BIT];
      clock_divider_select_q <= CTRL_RESET[SEL_W-1:0];
    end else if (pin_rst || (wd_ovf && !chip_reset_enable_q)) begin
      ovf_flag_q             <= 1'b0;
      mode_select_bit_q      <= 1'b0;
      count_enable_bit_q     <= 1'b0;
      clock_divider_select_q <= '0;
    end else begin
      if (key_wr && i_paddr == ADDR_CTRL_STATUS && i_pwdata[15:8] == KEY_CTRL) begin
        mode_select_bit_q      <= i_pwdata[CTRL_MODE_BIT];
        count_enable_bit_q     <= i_pwdata[CTRL_EN_BIT];
        clock_divider_select_q <= i_pwdata[CTRL_SEL_LSB +: SEL_W];
        if (!i_pwdata[CTRL_OVF_BIT]) begin
          ovf_flag_q <= 1'b0;
        end
      end
      if (it_ovf) begin
        ovf_flag_q <= 1'b1;
      end
    end
  end

  // Reset control/status; not touched by the watchdog's own chip reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_overflow_flag_q  <= 1'b0;
      chip_reset_enable_q <= 1'b0;
      reset_kind_select_q <= 1'b0;
    end else if (pin_rst || pwr_q != ST_RUN) begin
      wd_overflow_flag_q  <= 1'b0;
      chip_reset_enable_q <= 1'b0;
      reset_kind_select_q <= 1'b0;
    end else begin
      if (key_wr && i_paddr == ADDR_RESET_CTRL) begin
        if (i_pwdata[15:8] == KEY_RST_CLEAR && i_pwdata[7:0] == 8'h00) begin
          wd_overflow_flag_q <= 1'b0;
        end else if (i_pwdata[15:8] == KEY_RST_FIELD) begin
          chip_reset_enable_q <= i_pwdata[RST_ENBL_BIT];
          reset_kind_select_q <= i_pwdata[RST_KIND_BIT];
        end
      end
      if (wd_ovf) begin
        wd_overflow_flag_q <= 1'b1;
      end
    end
  end

  // Standby control; request refused while counting is enabled
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_q             <= ST_RUN;
      standby_refused_q <= 1'b0;
    end else if (pin_rst) begin
      pwr_q             <= ST_RUN;
      standby_refused_q <= 1'b0;
    end else begin
      unique case (pwr_q)
        ST_RUN: begin
          if (wr_en && i_paddr == ADDR_SYS_CTRL && i_pwdata[SYS_STBY_REQ_BIT]) begin
            if (count_enable_bit_q) begin
              standby_refused_q <= 1'b1;
            end else begin
              standby_refused_q <= 1'b0;
              pwr_q             <= ST_STBY;
            end
          end
        end
        ST_STBY: begin
          if (nmi_s) begin
            pwr_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (wake_done) begin
            pwr_q <= ST_RUN;
          end
        end
        default: pwr_q <= ST_RUN;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overflow_out_n    <= 1'b1;
      o_chip_reset        <= 1'b0;
      o_chip_reset_manual <= 1'b0;
      o_interval_irq      <= 1'b0;
      o_clock_release     <= 1'b1;
      o_in_standby        <= 1'b0;
    end else begin
      o_overflow_out_n    <= !(wd_ovf || ovf_active);
      o_chip_reset        <= rst_start || rst_active;
      o_chip_reset_manual <= reset_kind_select_q;
      o_interval_irq      <= it_ovf;
      o_clock_release     <= (pwr_q == ST_RUN) || wake_done;
      o_in_standby        <= (pwr_q != ST_RUN) && !wake_done;
    end
  end

  // APB read path and response
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          ADDR_CTRL_STATUS: o_prdata <= {24'h0, ovf_flag_q, mode_select_bit_q,
                                         count_enable_bit_q, 2'h3, clock_divider_select_q};
          ADDR_COUNTER:     o_prdata <= {24'h0, tick_counter_q};
          ADDR_RESET_CTRL:  o_prdata <= {24'h0, wd_overflow_flag_q, chip_reset_enable_q,
                                         reset_kind_select_q, RST_RSVD_ONES[4:0]};
          ADDR_SYS_CTRL:    o_prdata <= {29'h0, standby_refused_q,
                                         pwr_q != ST_RUN, 1'b0};
          default:          o_pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// ### logic/wdt_pkg.sv
package wdt_pkg;

  // Register byte addresses on the APB slave
  localparam logic [11:0] ADDR_CTRL_STATUS  = 12'h000;  // timer_ctrl_status read, keyed write
  localparam logic [11:0] ADDR_COUNTER      = 12'h004;  // tick_counter read
  localparam logic [11:0] ADDR_RESET_CTRL   = 12'h008;  // reset_ctrl_status read, keyed write
  localparam logic [11:0] ADDR_SYS_CTRL     = 12'h00C;  // standby request, standby and refused status

  // Write keys in the upper byte of a 16-bit write
  localparam logic [7:0] KEY_COUNTER   = 8'h5A;
  localparam logic [7:0] KEY_CTRL      = 8'hA5;
  localparam logic [7:0] KEY_RST_FIELD = 8'h5A;
  localparam logic [7:0] KEY_RST_CLEAR = 8'hA5;

  // timer_ctrl_status field positions
  localparam int CTRL_OVF_BIT  = 7;
  localparam int CTRL_MODE_BIT = 6;
  localparam int CTRL_EN_BIT   = 5;
  localparam int CTRL_SEL_LSB  = 0;
  localparam int SEL_W         = 3;

  // reset_ctrl_status field positions
  localparam int RST_FLAG_BIT = 7;
  localparam int RST_ENBL_BIT = 6;
  localparam int RST_KIND_BIT = 5;

  // Reserved bits read as ones
  localparam logic [7:0] CTRL_RSVD_ONES = 8'h18;
  localparam logic [7:0] RST_RSVD_ONES  = 8'h1F;

  // sys_ctrl field positions
  localparam int SYS_STBY_REQ_BIT = 0;
  localparam int SYS_STBY_BIT     = 1;
  localparam int SYS_REFUSED_BIT  = 2;

  // Reset values
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;

  // Divider select to prescaler tap (count tick when low tap bits all ones)
  localparam int PRESC_W = 13;
  localparam logic [3:0] TAP_DIV2    = 4'h1;
  localparam logic [3:0] TAP_DIV64   = 4'h6;
  localparam logic [3:0] TAP_DIV128  = 4'h7;
  localparam logic [3:0] TAP_DIV256  = 4'h8;
  localparam logic [3:0] TAP_DIV512  = 4'h9;
  localparam logic [3:0] TAP_DIV1024 = 4'hA;
  localparam logic [3:0] TAP_DIV4096 = 4'hC;
  localparam logic [3:0] TAP_DIV8192 = 4'hD;

  // Pulse timings at 200 MHz, one cycle per system clock
  localparam int         CLK_PERIOD_PS  = 5000;
  localparam int         OVF_PULSE_CYC  = 128;
  localparam int         RST_PULSE_CYC  = 512;
  // Start cycle is the first cycle of each pulse, so the stretcher adds one fewer
  localparam logic [9:0] OVF_PULSE_LAST = 10'(OVF_PULSE_CYC - 2);
  localparam logic [9:0] RST_PULSE_LAST = 10'(RST_PULSE_CYC - 2);

  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_STBY  = 3'h2,
    ST_WAKE  = 3'h4
  } pwr_state_e;

endpackage

// ### logic/wdt_prescaler.sv
`timescale 1ns/100ps
module wdt_prescaler
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  // Control
  input  wire logic               i_run,
  input  wire logic [SEL_W-1:0]   i_sel,
  // Tick
  output logic                    o_tick
);
  logic [PRESC_W-1:0] presc_q;
  logic [3:0]         tap;
  logic [PRESC_W-1:0] mask;

  // Prescaler resets while stopped so each start gives a full first period
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_q <= '0;
    end else if (!i_run) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  always_comb begin
    unique case (i_sel)
      3'h0: tap = TAP_DIV2;
      3'h1: tap = TAP_DIV64;
      3'h2: tap = TAP_DIV128;
      3'h3: tap = TAP_DIV256;
      3'h4: tap = TAP_DIV512;
      3'h5: tap = TAP_DIV1024;
      3'h6: tap = TAP_DIV4096;
      3'h7: tap = TAP_DIV8192;
    endcase
    mask = PRESC_W'((14'h0001 << tap) - 14'h0001);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_run && ((presc_q & mask) == mask);
    end
  end
endmodule

// ### logic/wdt_pulse.sv
`timescale 1ns/100ps
module wdt_pulse
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_start,
  input  wire logic [9:0] i_last,
  // Pulse
  output logic            o_active
);
  logic [9:0] cnt_q;

  // Active from the cycle after i_start for i_last+1 cycles
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_active <= 1'b0;
      cnt_q    <= '0;
    end else if (i_start && !o_active) begin
      o_active <= 1'b1;
      cnt_q    <= '0;
    end else if (o_active) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == i_last) begin
        o_active <= 1'b0;
      end
    end
  end
endmodule

// ### tb/sys_reset_circuit.sv
`timescale 1ns/100ps
module sys_reset_circuit (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Strobe from the watchdog
  input  wire logic i_overflow_out_n,
  // Observed pulses
  output int        o_pulses,
  output int        o_last_len
);
  int run;

  // Board reset only; never looped to the chip's own reset pin
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run <= 0;
      o_pulses <= 0;
      o_last_len <= 0;
    end else if (!i_overflow_out_n) begin // Active low strobe
      run <= run + 1;
    end else if (run != 0) begin
      o_pulses <= o_pulses + 1;
      o_last_len <= run;
      run <= 0;
    end
  end
endmodule

// ### tb/watchdog_interval_timer_bench.sv
`timescale 1ns/100ps
module watchdog_interval_timer_bench;
  import wdt_pkg::*;
  logic        i_core_clk, i_rst_n, psel, penable, pwrite, pin_n, nmi;
  logic        pready, pslverr, ovf_n, crst, cman, irq, crel, stby, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, strb;
  logic [7:0]  v;
  int          n_fail, n_checks, seed, cyc, cycles, npulse, plen, m_rst;
  int          m_div[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};

  watchdog_unit u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_external_reset_pin_n(pin_n), .i_nmi(nmi), .o_overflow_out_n(ovf_n),
    .o_chip_reset(crst), .o_chip_reset_manual(cman), .o_interval_irq(irq),
    .o_clock_release(crel), .o_in_standby(stby));
  sys_reset_circuit u_sys (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_overflow_out_n(ovf_n), .o_pulses(npulse), .o_last_len(plen));

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      $display("ERROR %0t: run hung", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int n, input int lo, input int hi);
    n_checks++;
    if (n < lo || n > hi) begin
      n_fail++;
      $display("ERROR %0t: %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask

  // One transfer; holds everything until ready is sampled, then idles a cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_sig(input int s, input logic lv, input int lim, output int n);
    logic [4:0] x;
    n = 0;
    x = {ovf_n, crst, irq, stby, 1'b0};
    while (x[4 - s] !== lv && n < lim) begin
      @(posedge i_core_clk);
      n++;
      x = {ovf_n, crst, irq, stby, 1'b0};
    end
    if (n >= lim) chk_rng(n, 0, lim - 1);
  endtask
  function automatic logic [31:0] rst_v();
    return {24'h0, 8'(m_rst) | RST_RSVD_ONES};
  endfunction

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    strb = 4'hF;
    pstrb = 4'hF;
    {pin_n, nmi, i_rst_n} = 3'b100;
    {n_fail, n_checks, cycles, m_rst} = '0;
    seed = 51;
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    rd_chk(ADDR_CTRL_STATUS, {24'h0, CTRL_RESET | CTRL_RSVD_ONES});
    rd_chk(ADDR_COUNTER, 32'h0);
    rd_chk(ADDR_RESET_CTRL, rst_v());
    apb(1'b1, 12'h010, 32'h0);
    chk(err, 1'b1);
    // Watchdog with internal manual reset; software lets it lapse on purpose
    apb(1'b1, ADDR_RESET_CTRL, {16'h0, KEY_RST_FIELD, 8'h60});
    m_rst = 'h60;
    apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_CTRL, 8'h60});
    wait_sig(0, 1'b0, 700, cyc);
    chk_rng(cyc, 505, 520);
    chk(crst, 1'b1);
    chk(cman, 1'b1);
    apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_CTRL, 8'h00});
    m_rst = 'hE0;
    rd_chk(ADDR_RESET_CTRL, rst_v());
    wait_sig(1, 1'b0, 700, cyc);
    chk(plen, 32'(OVF_PULSE_CYC));
    strb = 4'h1;
    apb(1'b1, ADDR_RESET_CTRL, {16'h0, KEY_RST_CLEAR, 8'h00});
    strb = 4'hF;
    apb(1'b1, ADDR_RESET_CTRL, {16'h0, 8'h5B, 8'h00});
    rd_chk(ADDR_RESET_CTRL, rst_v());
    apb(1'b1, ADDR_RESET_CTRL, {16'h0, KEY_RST_CLEAR, 8'h00});
    m_rst = 'h60;
    rd_chk(ADDR_RESET_CTRL, rst_v());
    // No internal reset: counter and control fall back instead
    apb(1'b1, ADDR_RESET_CTRL, {16'h0, KEY_RST_FIELD, 8'h00});
    m_rst = 0;
    apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_CTRL, 8'h60});
    wait_sig(0, 1'b0, 700, cyc);
    chk(crst, 1'b0);
    repeat (3) @(posedge i_core_clk);
    rd_chk(ADDR_CTRL_STATUS, {24'h0, CTRL_RSVD_ONES});
    rd_chk(ADDR_COUNTER, 32'h0);
    m_rst = 'h80;
    rd_chk(ADDR_RESET_CTRL, rst_v());
    wait_sig(0, 1'b1, 200, cyc);
    pin_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    pin_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    m_rst = 0;
    rd_chk(ADDR_RESET_CTRL, rst_v());
    // Interval mode from a random preload
    apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_CTRL, 8'h20});
    v = 8'h80 | 8'($random(seed) & 32'h7E);
    apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_COUNTER, v});
    wait_sig(2, 1'b1, 700, cyc);
    chk_rng(cyc, 2 * (256 - v) - 5, 2 * (256 - v) + 4);
    rd_chk(ADDR_CTRL_STATUS, {24'h0, 8'hA0 | CTRL_RSVD_ONES});
    wait_sig(2, 1'b1, 700, cyc);
    chk_rng(cyc, 500, 512);
    chk(npulse, 2);
    apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_CTRL, 8'h00});
    rd_chk(ADDR_COUNTER, 32'h0);
    // Every rate; stopped in the same write that changes the divider
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_CTRL, 8'(k)});
      apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_CTRL, 8'h20 | 8'(k)});
      apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_COUNTER, 8'hFE});
      wait_sig(2, 1'b1, 2 * m_div[k] + 20, cyc);
      chk_rng(cyc, 2 * m_div[k] - 4, 2 * m_div[k]);
    end
    // Standby only once counting is stopped; fastest rate covers settling
    apb(1'b1, ADDR_SYS_CTRL, 32'h1);
    rd_chk(ADDR_SYS_CTRL, 32'h4);
    apb(1'b1, ADDR_CTRL_STATUS, {16'h0, KEY_CTRL, 8'h00});
    apb(1'b1, ADDR_SYS_CTRL, 32'h1);
    @(posedge i_core_clk);
    chk({stby, crel}, 2'b10);
    nmi <= 1'b1;
    wait_sig(3, 1'b0, 700, cyc);
    chk_rng(cyc, 505, 530);
    chk(crel, 1'b1);
    nmi <= 1'b0;
    give_verdict();
  end
endmodule

// ### tb/watchdog_unit_checker.sv
`timescale 1ns/100ps
module watchdog_unit_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_overflow_out_n,
  input wire logic o_chip_reset,
  input wire logic o_interval_irq,
  input wire logic o_clock_release,
  input wire logic o_in_standby
);
  logic [9:0] low_q;
  logic [9:0] hi_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Lengths counted in helpers, too long for a repetition
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) low_q <= 10'h000;
    else low_q <= o_overflow_out_n ? 10'h000 : low_q + 10'h001;
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) hi_q <= 10'h000;
    else hi_q <= o_chip_reset ? hi_q + 10'h001 : 10'h000;
  end

  sequence s_ovf_start;
    $fell(o_overflow_out_n);
  endsequence
  sequence s_rst_start;
    $rose(o_chip_reset);
  endsequence

  a_ovf_min_len: assert property ($rose(o_overflow_out_n) |-> low_q == 10'd128)
    else $error("overflow pulse too short");
  a_ovf_max_len: assert property (low_q <= 10'd128)
    else $error("overflow pulse too long");
  a_ovf_holds: assert property (s_ovf_start |-> !o_overflow_out_n [*8])
    else $error("overflow pulse broke early");
  a_rst_min_len: assert property ($fell(o_chip_reset) |-> hi_q == 10'd512)
    else $error("chip reset too short");
  a_rst_max_len: assert property (hi_q <= 10'd512)
    else $error("chip reset too long");
  a_rst_with_ovf: assert property (s_rst_start |-> s_ovf_start)
    else $error("chip reset not aligned to overflow");
  a_irq_one_cycle: assert property (o_interval_irq |=> !o_interval_irq)
    else $error("interval irq longer than one cycle");
  a_apb_zero_wait: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready in access cycle");
  a_stby_clocks: assert property (o_clock_release != o_in_standby)
    else $error("clock release disagrees with standby");
endmodule

bind watchdog_unit watchdog_unit_checker u_checker (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_overflow_out_n(o_overflow_out_n), .o_chip_reset(o_chip_reset),
  .o_interval_irq(o_interval_irq), .o_clock_release(o_clock_release),
  .o_in_standby(o_in_standby));
